// ---- atr_pkg.sv ----
package atr_pkg;
   // register byte offsets
   localparam logic [4:0] OFF_STATUS = 5'h00;
   localparam logic [4:0] OFF_CTRL   = 5'h04;
   localparam logic [4:0] OFF_DATA   = 5'h08;
   localparam logic [4:0] OFF_CFG    = 5'h0c;
   localparam logic [4:0] OFF_BAUD   = 5'h10;
   // status bits
   localparam int unsigned ST_TX_BUFFER_EMPTY_FLAG = 7;
   localparam int unsigned ST_TC   = 6;
   localparam int unsigned ST_RX_BUFFER_FULL_FLAG = 5;
   localparam int unsigned ST_OVR  = 3;
   localparam int unsigned ST_FE   = 1;
   // control bits
   localparam int unsigned CT_TE  = 3;
   localparam int unsigned CT_RE  = 2;
   localparam int unsigned CT_SBK = 0;
   // config bits
   localparam int unsigned CF_NINE  = 0;
   localparam int unsigned CF_TWO   = 1;
   localparam int unsigned CF_LONG  = 2;
   localparam int unsigned CF_TX_POLARITY_INVERT = 3;
   localparam int unsigned CF_RX_POLARITY_INVERT = 4;
   // baud divider
   localparam int unsigned        BAUD_W       = 13;
   localparam logic [BAUD_W-1:0]  BAUD_RST_VAL = 13'h0001;
   // 16x sample positions, rt16 wraps to zero
   localparam logic [3:0] RT_EDGE  = 4'h1;
   localparam logic [3:0] RT_S1    = 4'h3;
   localparam logic [3:0] RT_S2    = 4'h5;
   localparam logic [3:0] RT_S3    = 4'h7;
   localparam logic [3:0] RT_D1    = 4'h8;
   localparam logic [3:0] RT_D2    = 4'h9;
   localparam logic [3:0] RT_D3    = 4'ha;
   localparam logic [3:0] RT_END   = 4'h0;
   localparam logic [3:0] SUB_LAST = 4'hf;
   localparam logic [1:0] MAJ      = 2'h2;
   localparam logic [2:0] HIST_HI  = 3'h7;
   // frame geometry
   localparam logic [3:0]  FRAME_BASE = 4'ha;
   localparam logic [3:0]  LONG_EXTRA = 4'h3;
   localparam logic [3:0]  BITS8      = 4'h8;
   localparam logic [3:0]  BITS9      = 4'h9;
   localparam int unsigned SH_W       = 15;

   function automatic logic [3:0] frame_len(input logic nine, input logic two);
      frame_len = FRAME_BASE + {3'h0, nine} + {3'h0, two};
   endfunction : frame_len

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b001,
      RX_START = 3'b010,
      RX_DATA  = 3'b100
   } atr_rx_state_e;

   typedef struct packed {
      logic [SH_W-1:0] sh;
      logic [3:0]      cnt;
      logic [3:0]      sub;
      logic            pre_q;
      logic            brk_q;
      logic            te_d;
      logic            sbk_d;
      logic            tx_buffer_empty_flag;
      logic            tc;
      logic [8:0]      tbuf;
      logic            txd;
      logic            oe_n;
   } atr_tx_s;

   typedef struct packed {
      atr_rx_state_e state;
      logic [3:0]    rt;
      logic [2:0]    hist;
      logic [1:0]    vote;
      logic [3:0]    bitn;
      logic [8:0]    sh;
      logic [8:0]    rbuf;
      logic          rx_buffer_full_flag;
      logic          ovr;
      logic          fe;
   } atr_rx_s;

   localparam atr_tx_s TX_RST = '{sh: '1, cnt: '0, sub: '0, pre_q: 1'b0, brk_q: 1'b0,
                                  te_d: 1'b0, sbk_d: 1'b0, tx_buffer_empty_flag: 1'b1, tc: 1'b1,
                                  tbuf: '0, txd: 1'b1, oe_n: 1'b1};
   localparam atr_rx_s RX_RST = '{state: RX_IDLE, rt: '0, hist: '0, vote: '0, bitn: '0,
                                  sh: '0, rbuf: '0, rx_buffer_full_flag: 1'b0, ovr: 1'b0, fe: 1'b0};
endpackage : atr_pkg

// ---- atr_link_if.sv ----
`timescale 1ns/1ps
interface atr_link_if;
   logic dev_txd;
   logic dev_tx_oe_n;
   logic peer_txd;
   logic tx_line;

   // line is pulled up while the device has released it
   assign tx_line = dev_tx_oe_n ? 1'b1 : dev_txd;

   modport device (output dev_txd, output dev_tx_oe_n, input peer_txd);
   modport peer (input tx_line, output peer_txd);
endinterface : atr_link_if

// ---- atr_device.sv ----
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module atr_device #(
   parameter logic [atr_pkg::BAUD_W-1:0] BAUD_RST = atr_pkg::BAUD_RST_VAL
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // wishbone slave
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // serial link
   atr_link_if.device       link
);
   logic [3:0]                 ctrl, next_ctrl;
   logic [4:0]                 cfg, next_cfg;
   logic [atr_pkg::BAUD_W-1:0] baud, next_baud;
   logic [atr_pkg::BAUD_W-1:0] bcnt, next_bcnt;
   logic                       tx_armed, next_tx_armed;
   logic                       rx_armed, next_rx_armed;
   logic                       next_ack;
   logic [31:0]                next_rdat;
   atr_pkg::atr_tx_s           tx, next_tx;
   atr_pkg::atr_rx_s           rx, next_rx;
   logic                       acc, rd_st, rd_dat, wr_dat, tick, bit_tick, clr_rx, tx_take;
   logic [3:0]                 flen, nbits;

   function automatic logic is_at(input logic [4:0] off);
      is_at = acc && (wb_adr_i == off);
   endfunction : is_at

   assign acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign rd_st    = is_at(atr_pkg::OFF_STATUS) & ~wb_we_i;
   assign rd_dat   = is_at(atr_pkg::OFF_DATA) & ~wb_we_i;
   assign wr_dat   = is_at(atr_pkg::OFF_DATA) & wb_we_i & wb_sel_i[0];
   assign tick     = (baud != '0) && (bcnt >= baud - 13'h1);
   assign bit_tick = tick && (tx.sub == atr_pkg::SUB_LAST);
   assign clr_rx   = rd_dat & rx_armed;
   assign tx_take  = wr_dat & tx_armed & tx.tx_buffer_empty_flag;
   assign flen     = atr_pkg::frame_len(cfg[atr_pkg::CF_NINE], cfg[atr_pkg::CF_TWO]);
   assign nbits    = cfg[atr_pkg::CF_NINE] ? atr_pkg::BITS9 : atr_pkg::BITS8;

   // register file and bus answer
   always_comb begin
      next_ctrl     = ctrl;
      next_cfg      = cfg;
      next_baud     = baud;
      next_ack      = acc;
      next_rdat     = '0;
      next_tx_armed = tx_armed;
      next_rx_armed = rx_armed;
      next_bcnt     = tick ? '0 : bcnt + 13'h1;
      if (acc & wb_we_i & wb_sel_i[0]) begin
         case (wb_adr_i)
            atr_pkg::OFF_CTRL: next_ctrl = wb_dat_i[3:0];
            atr_pkg::OFF_CFG:  next_cfg = wb_dat_i[4:0];
            atr_pkg::OFF_BAUD: next_baud = wb_dat_i[atr_pkg::BAUD_W-1:0];
            default: ;
         endcase
      end
      if (acc & ~wb_we_i) begin
         case (wb_adr_i)
            atr_pkg::OFF_STATUS: begin
               next_rdat[atr_pkg::ST_TX_BUFFER_EMPTY_FLAG] = tx.tx_buffer_empty_flag;
               next_rdat[atr_pkg::ST_TC]   = tx.tc;
               next_rdat[atr_pkg::ST_RX_BUFFER_FULL_FLAG] = rx.rx_buffer_full_flag;
               next_rdat[atr_pkg::ST_OVR]  = rx.ovr;
               next_rdat[atr_pkg::ST_FE]   = rx.fe;
            end
            atr_pkg::OFF_CTRL: next_rdat[3:0] = ctrl;
            atr_pkg::OFF_DATA: next_rdat[8:0] = rx.rbuf;
            atr_pkg::OFF_CFG:  next_rdat[4:0] = cfg;
            atr_pkg::OFF_BAUD: next_rdat[atr_pkg::BAUD_W-1:0] = baud;
            default: ;
         endcase
      end
      if (rd_st & tx.tx_buffer_empty_flag) next_tx_armed = 1'b1;
      else if (wr_dat) next_tx_armed = 1'b0;
      if (rd_st & (rx.rx_buffer_full_flag | rx.ovr | rx.fe)) next_rx_armed = 1'b1;
      else if (rd_dat) next_rx_armed = 1'b0;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl     <= '0;
         cfg      <= '0;
         baud     <= BAUD_RST;
         bcnt     <= '0;
         tx_armed <= 1'b0;
         rx_armed <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         ctrl     <= next_ctrl;
         cfg      <= next_cfg;
         baud     <= next_baud;
         bcnt     <= next_bcnt;
         tx_armed <= next_tx_armed;
         rx_armed <= next_rx_armed;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_rdat;
      end
   end

   // transmitter: preamble first, then break, then data
   always_comb begin
      next_tx       = tx;
      next_tx.te_d  = ctrl[atr_pkg::CT_TE];
      next_tx.sbk_d = ctrl[atr_pkg::CT_SBK];
      if (tick) next_tx.sub = tx.sub + 4'h1;
      if (tx_take) begin
         next_tx.tbuf = wb_dat_i[8:0];
         next_tx.tx_buffer_empty_flag = 1'b0;
         next_tx.tc   = 1'b0;
      end
      if (bit_tick) begin
         if (tx.cnt > 4'h1) begin
            next_tx.sh  = tx.sh >> 1;
            next_tx.cnt = tx.cnt - 4'h1;
         end else begin
            next_tx.cnt = '0;
            next_tx.sh  = '1;
            if (tx.pre_q) begin
               next_tx.cnt   = flen;
               next_tx.pre_q = 1'b0;
               next_tx.tc    = 1'b0;
            end else if (tx.brk_q) begin
               next_tx.sh    = '0;
               next_tx.cnt   = flen + (cfg[atr_pkg::CF_LONG] ? atr_pkg::LONG_EXTRA : 4'h0);
               next_tx.brk_q = ctrl[atr_pkg::CT_SBK];
               next_tx.tc    = 1'b0;
            end else if (!tx.tx_buffer_empty_flag && ctrl[atr_pkg::CT_TE]) begin
               next_tx.sh[0]   = 1'b0;
               next_tx.sh[8:1] = tx.tbuf[7:0];
               if (cfg[atr_pkg::CF_NINE]) next_tx.sh[9] = tx.tbuf[8];
               next_tx.cnt  = flen;
               next_tx.tx_buffer_empty_flag = 1'b1;
               next_tx.tc   = 1'b0;
            end else if (tx.cnt == 4'h1) begin
               next_tx.tc = 1'b1;
            end
         end
      end
      // queue events after the load so a new request is never lost
      if (ctrl[atr_pkg::CT_TE] & ~tx.te_d) begin
         next_tx.pre_q = 1'b1;
         next_tx.tc    = 1'b0;
      end
      if (ctrl[atr_pkg::CT_SBK] & ~tx.sbk_d) begin
         next_tx.brk_q = 1'b1;
         next_tx.tc    = 1'b0;
      end
      next_tx.txd  = ((next_tx.cnt != '0) ? next_tx.sh[0] : 1'b1)
                     ^ cfg[atr_pkg::CF_TX_POLARITY_INVERT];
      next_tx.oe_n = ~(ctrl[atr_pkg::CT_TE] | (next_tx.cnt != '0)
                       | next_tx.pre_q | next_tx.brk_q);
   end

   // receiver: majority voting on 16x ticks
   always_comb begin
      logic       s;
      logic       fall;
      logic       bitv;
      logic [3:0] nrt;
      logic [1:0] nvote;
      s       = link.peer_txd ^ cfg[atr_pkg::CF_RX_POLARITY_INVERT];
      fall    = rx.hist[0] & ~s;
      nrt     = rx.rt + 4'h1;
      nvote   = rx.vote;
      bitv    = 1'b0;
      next_rx = rx;
      if (clr_rx) begin
         next_rx.rx_buffer_full_flag = 1'b0;
         next_rx.ovr  = 1'b0;
         next_rx.fe   = 1'b0;
      end
      if (!ctrl[atr_pkg::CT_RE]) begin
         next_rx.state = atr_pkg::RX_IDLE;
         next_rx.hist  = '0;
      end else if (tick) begin
         next_rx.hist = {rx.hist[1:0], s};
         next_rx.rt   = nrt;
         unique case (rx.state)
            atr_pkg::RX_IDLE: begin
               if (rx.hist == atr_pkg::HIST_HI && !s) begin
                  next_rx.state = atr_pkg::RX_START;
                  next_rx.rt    = atr_pkg::RT_EDGE;
                  next_rx.vote  = '0;
               end
            end
            atr_pkg::RX_START: begin
               if ((nrt == atr_pkg::RT_S1 || nrt == atr_pkg::RT_S2 || nrt == atr_pkg::RT_S3)
                   && !s) nvote = rx.vote + 2'h1;
               next_rx.vote = nvote;
               if (nrt == atr_pkg::RT_S3 && nvote < atr_pkg::MAJ)
                  next_rx.state = atr_pkg::RX_IDLE;
               else if (nrt == atr_pkg::RT_END) begin
                  next_rx.state = atr_pkg::RX_DATA;
                  next_rx.bitn  = '0;
                  next_rx.vote  = '0;
               end
            end
            atr_pkg::RX_DATA: begin
               if ((nrt == atr_pkg::RT_D1 || nrt == atr_pkg::RT_D2 || nrt == atr_pkg::RT_D3)
                   && s) nvote = rx.vote + 2'h1;
               next_rx.vote = nvote;
               bitv = (nvote >= atr_pkg::MAJ);
               if (nrt == atr_pkg::RT_D3) begin
                  if (rx.bitn < nbits) begin
                     next_rx.sh = {bitv, rx.sh[8:1]};
                  end else begin
                     next_rx.state = atr_pkg::RX_IDLE;
                     // a set from a new frame wins over the clear above
                     if (!bitv) next_rx.fe = 1'b1;
                     else if (!next_rx.fe) begin
                        if (next_rx.rx_buffer_full_flag) next_rx.ovr = 1'b1;
                        else begin
                           next_rx.rbuf = cfg[atr_pkg::CF_NINE] ? rx.sh
                                          : {1'b0, rx.sh[8:1]};
                           next_rx.rx_buffer_full_flag = 1'b1;
                        end
                     end
                  end
               end
               if (nrt == atr_pkg::RT_END) begin
                  next_rx.bitn = rx.bitn + 4'h1;
                  next_rx.vote = '0;
               end
               if (fall) begin
                  next_rx.rt   = atr_pkg::RT_EDGE;
                  next_rx.vote = '0;
               end
            end
            default: next_rx.state = atr_pkg::RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         tx <= atr_pkg::TX_RST;
         rx <= atr_pkg::RX_RST;
      end else begin
         tx <= next_tx;
         rx <= next_rx;
      end
   end

   assign link.dev_txd     = tx.txd;
   assign link.dev_tx_oe_n = tx.oe_n;
endmodule : atr_device

// ---- atr_peer.sv ----
`timescale 1ns/1ps
// remote transceiver; no resync, one centre sample per bit
module atr_peer #(
   parameter int unsigned DIV = 4
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // frame format
   input  wire logic       nine_bit,
   input  wire logic       two_stop,
   // send side
   input  wire logic       send_valid,
   input  wire logic [8:0] send_data,
   output logic            send_ready,
   // receive side
   output logic            recv_valid,
   output logic [8:0]      recv_data,
   output logic            recv_frame_err,
   // serial link
   atr_link_if.peer        link
);
   typedef enum logic [1:0] {P_IDLE = 2'b01, P_BUSY = 2'b10} atr_prx_e;

   logic [15:0]              dcnt, next_dcnt;
   logic [3:0]               sub, next_sub, tcnt, next_tcnt, rrt, next_rrt, rbit, next_rbit;
   logic [atr_pkg::SH_W-1:0] tsh, next_tsh;
   logic [8:0]               rsh, next_rsh, next_rdata, sbuf, next_sbuf;
   logic                     lhi, next_lhi;
   logic                     pend, next_pend, next_ready, txd, next_txd;
   logic                     next_rvalid, next_rerr;
   atr_prx_e                 rst_q, next_rst_q;
   logic                     tick;
   logic [3:0]               nrt;

   assign tick = (dcnt == 16'(DIV - 1));
   assign nrt  = rrt + 4'h1;

   always_comb begin
      next_dcnt   = tick ? '0 : dcnt + 16'h1;
      next_sub    = tick ? sub + 4'h1 : sub;
      next_tsh    = tsh;
      next_tcnt   = tcnt;
      next_pend   = pend;
      next_rst_q  = rst_q;
      next_rrt    = rrt;
      next_rbit   = rbit;
      next_rsh    = rsh;
      next_rvalid = 1'b0;
      next_rdata  = recv_data;
      next_rerr   = recv_frame_err;
      next_sbuf   = sbuf;
      next_lhi    = lhi;
      // data is held here so the sender may move on once it is taken
      if (send_valid & send_ready) begin
         next_pend = 1'b1;
         next_sbuf = send_data;
      end
      if (tick && sub == atr_pkg::SUB_LAST) begin
         if (tcnt > 4'h1) begin
            next_tsh  = tsh >> 1;
            next_tcnt = tcnt - 4'h1;
         end else if (pend) begin
            next_tsh        = '1;
            next_tsh[0]     = 1'b0;
            next_tsh[8:1]   = sbuf[7:0];
            if (nine_bit) next_tsh[9] = sbuf[8];
            next_tcnt       = atr_pkg::frame_len(nine_bit, two_stop);
            next_pend       = 1'b0;
         end else next_tcnt = '0;
      end
      if (tick) begin
         next_lhi = link.tx_line;
         unique case (rst_q)
            // a start needs a falling edge, so a long break is one frame
            P_IDLE: if (!link.tx_line && lhi) begin
               next_rst_q = P_BUSY;
               next_rrt   = atr_pkg::RT_EDGE;
               next_rbit  = '0;
            end
            P_BUSY: begin
               next_rrt = nrt;
               if (nrt == atr_pkg::RT_D2) begin
                  if (rbit == '0) begin
                     if (link.tx_line) next_rst_q = P_IDLE;
                  end else if (rbit <= (nine_bit ? atr_pkg::BITS9 : atr_pkg::BITS8)) begin
                     next_rsh = {link.tx_line, rsh[8:1]};
                  end else begin
                     next_rst_q  = P_IDLE;
                     next_rvalid = 1'b1;
                     next_rdata  = nine_bit ? rsh : {1'b0, rsh[8:1]};
                     next_rerr   = ~link.tx_line;
                  end
               end
               if (nrt == atr_pkg::RT_END) next_rbit = rbit + 4'h1;
            end
            default: next_rst_q = P_IDLE;
         endcase
      end
      next_ready = ~next_pend;
      next_txd   = (next_tcnt != '0) ? next_tsh[0] : 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         dcnt           <= '0;
         sub            <= '0;
         tsh            <= '1;
         tcnt           <= '0;
         pend           <= 1'b0;
         send_ready     <= 1'b0;
         txd            <= 1'b1;
         rst_q          <= P_IDLE;
         rrt            <= '0;
         rbit           <= '0;
         rsh            <= '0;
         sbuf           <= '0;
         lhi            <= 1'b1;
         recv_valid     <= 1'b0;
         recv_data      <= '0;
         recv_frame_err <= 1'b0;
      end else begin
         dcnt           <= next_dcnt;
         sub            <= next_sub;
         tsh            <= next_tsh;
         tcnt           <= next_tcnt;
         pend           <= next_pend;
         send_ready     <= next_ready;
         txd            <= next_txd;
         rst_q          <= next_rst_q;
         rrt            <= next_rrt;
         rbit           <= next_rbit;
         rsh            <= next_rsh;
         sbuf           <= next_sbuf;
         lhi            <= next_lhi;
         recv_valid     <= next_rvalid;
         recv_data      <= next_rdata;
         recv_frame_err <= next_rerr;
      end
   end

   assign link.peer_txd = txd;
endmodule : atr_peer

// ---- atr_link_checker.sv ----
`timescale 1ns/1ps
module atr_link_checker #(
   parameter int unsigned DIV = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // serial link
   input wire logic dev_txd,
   input wire logic dev_tx_oe_n,
   input wire logic peer_txd,
   input wire logic tx_line
);
   localparam logic [19:0] BITW = 20'(16 * DIV);
   localparam logic [19:0] BRKW = 20'(15 * 16 * DIV);
   localparam logic [19:0] FRMW = 20'(10 * 16 * DIV);
   logic [19:0] run;
   logic [19:0] prun;
   logic [19:0] drv;
   logic        d_q;
   logic        p_q;
   logic        armed;
   logic        idle_lvl;
   logic        chg;
   logic        prise;
   assign chg   = dev_txd != d_q;
   assign prise = peer_txd && !p_q;
   // first change after drive start is not judged: the bit grid is unknown until then
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         run      <= '0;
         prun     <= '0;
         drv      <= '0;
         d_q      <= 1'b1;
         p_q      <= 1'b1;
         armed    <= 1'b0;
         idle_lvl <= 1'b1;
      end else begin
         run   <= chg ? 20'h1 : run + 20'h1;
         prun  <= (peer_txd != p_q) ? 20'h1 : prun + 20'h1;
         drv   <= dev_tx_oe_n ? 20'h0 : drv + 20'h1;
         d_q   <= dev_txd;
         p_q   <= peer_txd;
         armed <= !dev_tx_oe_n && (armed || chg);
         if (!dev_tx_oe_n && drv == 20'h0) idle_lvl <= dev_txd;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   reset_idle_a:
      assert property ($rose(nrst) |-> dev_txd && dev_tx_oe_n)
      else $error("device line not idle after reset");
   peer_idle_a:
      assert property ($rose(nrst) |-> peer_txd [*2])
      else $error("peer line not idle after reset");
   tx_bit_grid_a:
      assert property (chg && armed && !dev_tx_oe_n |-> run % BITW == 20'h0)
      else $error("device bit edge off the bit grid");
   break_max_a:
      assert property (chg && armed && d_q != idle_lvl |-> run <= BRKW)
      else $error("device active run longer than longest break");
   preamble_hold_a:
      assert property ($rose(dev_tx_oe_n) |-> drv >= FRMW)
      else $error("line released before a full preamble");
   release_idle_a:
      assert property ($rose(dev_tx_oe_n) |-> d_q == idle_lvl && run >= BITW)
      else $error("line released in mid character");
   peer_grid_a:
      assert property (prise |-> prun % BITW == 20'h0)
      else $error("peer low run off the bit grid");
   peer_zero_max_a:
      assert property (prise |-> prun <= FRMW && $past(peer_txd, 1) == 1'b0)
      else $error("peer low run longer than a frame");
   line_pulled_a:
      assert property (dev_tx_oe_n |-> tx_line)
      else $error("released device line not high");
endmodule : atr_link_checker

// ---- async_serial_tx_rx_core_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
   check_count++; \
   if ((got) !== (ex)) begin \
      error_cnt++; \
      $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
   end \
end
module async_serial_tx_rx_core_tb_top;
   logic        sys_clk = 1'b0;
   logic        nrst    = 1'b0;
   logic [4:0]  adr     = '0;
   logic [31:0] wdat    = '0;
   logic        we      = 1'b0;
   logic        cyc     = 1'b0;
   logic        nine    = 1'b0;
   logic        two     = 1'b0;
   logic        s_valid = 1'b0;
   logic [8:0]  s_data  = '0;
   logic [31:0] rdat;
   logic        ack;
   logic        s_ready;
   logic        r_valid;
   logic [8:0]  r_data;
   logic        r_ferr;
   logic [31:0] q;
   int          error_cnt   = 0;
   int          check_count = 0;
   int          rx_seen     = 0;
   atr_link_if atr_link_if_i ();
   // stb follows cyc: classic single cycles only
   atr_device atr_device_i (.sys_clk(sys_clk), .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat),
      .wb_ack_o(ack), .link(atr_link_if_i));
   atr_peer #(.DIV(4)) atr_peer_i (.sys_clk(sys_clk), .nrst(nrst), .nine_bit(nine),
      .two_stop(two), .send_valid(s_valid), .send_data(s_data), .send_ready(s_ready),
      .recv_valid(r_valid), .recv_data(r_data), .recv_frame_err(r_ferr), .link(atr_link_if_i));
   atr_link_checker #(.DIV(4)) atr_link_checker_i (.sys_clk(sys_clk), .nrst(nrst),
      .dev_txd(atr_link_if_i.dev_txd), .dev_tx_oe_n(atr_link_if_i.dev_tx_oe_n),
      .peer_txd(atr_link_if_i.peer_txd), .tx_line(atr_link_if_i.tx_line));
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (r_valid === 1'b1) rx_seen++;
   end
   task automatic test_done();
      if (error_cnt == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   task automatic tmo(input int n, input int lim);
      if (n >= lim) begin
         error_cnt++;
         test_done();
      end
   endtask : tmo
   task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d);
      int n;
      adr  <= a;
      we   <= w;
      wdat <= d;
      cyc  <= 1'b1;
      for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge sys_clk);
      tmo(n, 20);
      q = rdat;
      cyc <= 1'b0;
      @(posedge sys_clk);
   endtask : wb
   task automatic poll(input int b);
      int n;
      for (n = 0; n < 1500; n++) begin
         wb(atr_pkg::OFF_STATUS, 1'b0, 32'h0);
         if (q[b] === 1'b1) break;
      end
      tmo(n, 1500);
   endtask : poll
   task automatic tx_char(input logic [8:0] d);
      poll(atr_pkg::ST_TX_BUFFER_EMPTY_FLAG);
      wb(atr_pkg::OFF_DATA, 1'b1, {23'h0, d});
   endtask : tx_char
   task automatic peer_rx(input logic [8:0] e);
      int n;
      for (n = 0; n < 3000 && r_valid !== 1'b1; n++) @(posedge sys_clk);
      tmo(n, 3000);
      `CHK("peer data", e, r_data)
      @(posedge sys_clk);
   endtask : peer_rx
   task automatic peer_tx(input logic [8:0] d);
      int n;
      s_data  <= d;
      s_valid <= 1'b1;
      for (n = 0; n < 2000; n++) begin
         @(posedge sys_clk);
         if (s_ready === 1'b1) break;
      end
      tmo(n, 2000);
      s_valid <= 1'b0;
      @(posedge sys_clk);
   endtask : peer_tx
   task automatic wait_release();
      int n;
      for (n = 0; n < 3000 && atr_link_if_i.dev_tx_oe_n !== 1'b1; n++) @(posedge sys_clk);
      tmo(n, 3000);
   endtask : wait_release
   task automatic t_reset();
      wb(atr_pkg::OFF_STATUS, 1'b0, 32'h0);
      `CHK("status", 32'hc0, q)
      wb(5'h14, 1'b0, 32'h0);
      `CHK("unmapped", 32'h0, q)
      `CHK("line idle", 1'b1, atr_link_if_i.tx_line)
   endtask : t_reset
   task automatic t_tx();
      wb(atr_pkg::OFF_BAUD, 1'b1, 32'h4);
      wb(atr_pkg::OFF_CTRL, 1'b1, 32'hc);
      tx_char(9'h0a5);
      peer_rx(9'h0a5);
      wb(atr_pkg::OFF_DATA, 1'b1, 32'h1ff);
      poll(atr_pkg::ST_TC);
      `CHK("refused write", 1, rx_seen)
      tx_char(9'h03c);
      tx_char(9'h0c3);
      peer_rx(9'h03c);
      peer_rx(9'h0c3);
      poll(atr_pkg::ST_TC);
      wb(atr_pkg::OFF_CFG, 1'b1, 32'h3);
      nine <= 1'b1;
      two  <= 1'b1;
      tx_char(9'h155);
      peer_rx(9'h155);
      peer_tx(9'h1c6);
      poll(atr_pkg::ST_RX_BUFFER_FULL_FLAG);
      wb(atr_pkg::OFF_DATA, 1'b0, 32'h0);
      `CHK("nine rx", 9'h1c6, q[8:0])
      // let the second stop bit pass before the peer format changes
      repeat (128) @(posedge sys_clk);
      wb(atr_pkg::OFF_CFG, 1'b1, 32'h0);
      nine <= 1'b0;
      two  <= 1'b0;
   endtask : t_tx
   task automatic t_rx();
      peer_tx(9'h05a);
      poll(atr_pkg::ST_RX_BUFFER_FULL_FLAG);
      wb(atr_pkg::OFF_DATA, 1'b0, 32'h0);
      `CHK("rx data", 9'h05a, q[8:0])
      wb(atr_pkg::OFF_STATUS, 1'b0, 32'h0);
      `CHK("full cleared", 1'b0, q[atr_pkg::ST_RX_BUFFER_FULL_FLAG])
      peer_tx(9'h011);
      peer_tx(9'h022);
      poll(atr_pkg::ST_OVR);
      wb(atr_pkg::OFF_STATUS, 1'b1, 32'h0);
      wb(atr_pkg::OFF_STATUS, 1'b0, 32'h0);
      `CHK("no write clear", 1'b1, q[atr_pkg::ST_RX_BUFFER_FULL_FLAG])
      wb(atr_pkg::OFF_DATA, 1'b0, 32'h0);
      `CHK("kept char", 9'h011, q[8:0])
      wb(atr_pkg::OFF_STATUS, 1'b0, 32'h0);
      `CHK("flags", 2'h0, {q[atr_pkg::ST_RX_BUFFER_FULL_FLAG], q[atr_pkg::ST_OVR]})
      wb(atr_pkg::OFF_CTRL, 1'b1, 32'h8);
      peer_tx(9'h033);
      repeat (704) @(posedge sys_clk);
      wb(atr_pkg::OFF_STATUS, 1'b0, 32'h0);
      `CHK("rx off", 1'b0, q[atr_pkg::ST_RX_BUFFER_FULL_FLAG])
      wb(atr_pkg::OFF_CTRL, 1'b1, 32'hc);
   endtask : t_rx
   task automatic t_brk();
      int n;
      int len;
      logic [31:0] cfg [3] = '{32'h0, 32'h4, 32'h7};
      int bits [3] = '{10, 13, 15};
      // one character first puts the writes clear of a bit tick,
      // else a break could load while the control is still set
      tx_char(9'h000);
      peer_rx(9'h000);
      for (int i = 0; i < 3; i++) begin
         wb(atr_pkg::OFF_CFG, 1'b1, cfg[i]);
         wb(atr_pkg::OFF_CTRL, 1'b1, 32'hd);
         wb(atr_pkg::OFF_CTRL, 1'b1, 32'hc);
         for (n = 0; n < 300 && atr_link_if_i.tx_line === 1'b1; n++) @(posedge sys_clk);
         tmo(n, 300);
         for (len = 0; len < 2000 && atr_link_if_i.tx_line === 1'b0; len++) @(posedge sys_clk);
         `CHK("break len", bits[i] * 64, len)
         `CHK("break seen", 1'b1, r_ferr)
      end
      wb(atr_pkg::OFF_CFG, 1'b1, 32'h0);
   endtask : t_brk
   task automatic t_te();
      tx_char(9'h096);
      poll(atr_pkg::ST_TX_BUFFER_EMPTY_FLAG);
      wb(atr_pkg::OFF_CTRL, 1'b1, 32'h4);
      wb(atr_pkg::OFF_CTRL, 1'b1, 32'hc);
      `CHK("line kept", 1'b0, atr_link_if_i.dev_tx_oe_n)
      peer_rx(9'h096);
      wb(atr_pkg::OFF_CTRL, 1'b1, 32'h4);
      `CHK("line held", 1'b0, atr_link_if_i.dev_tx_oe_n)
      wait_release();
      wb(atr_pkg::OFF_CFG, 1'b1, 32'h8);
      wb(atr_pkg::OFF_CTRL, 1'b1, 32'hc);
      repeat (2) @(posedge sys_clk);
      `CHK("inverted idle", 1'b0, atr_link_if_i.tx_line)
      wb(atr_pkg::OFF_CTRL, 1'b1, 32'h4);
      wait_release();
   endtask : t_te
   initial begin
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_tx();
      t_rx();
      t_brk();
      t_te();
      test_done();
   end
endmodule : async_serial_tx_rx_core_tb_top
